// ===== hdl/ddlc_host.sv
// Operation
// - Channel select low A, high B
// - Byte select low low-byte, high nibble
// - Nibble right-justified on low data lines
// - Write high at reset release keeps zeros
`include "ddlc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddlc_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_chan,
  input  wire logic [11:0] req_code,
  input  wire logic        req_hi_first,
  input  wire logic        req_transfer,
  input  wire logic        dev_rst_req,
  output logic             done,
  output logic [7:0]       dac_data_q,
  output logic             chan_sel_q,
  output logic             byte_sel_q,
  output logic             write_n_q,
  output logic             transfer_strobe_n_q,
  output logic             reset_n_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  ddlc_pkg::ddlc_state_e state_q;
  ddlc_pkg::ddlc_phase_e phase_q;
  logic [3:0]            cnt_q;
  logic [11:0]           code_q;
  logic                  chan_q;
  logic                  hi_first_q;
  logic                  xfer_q;
  logic                  second_q;
  logic                  done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Nibble sits right-justified; upper lines driven zero so a device that
  // decodes all eight lines still sees the intended code
  function automatic logic [7:0] ddlc_lane(input logic [11:0] code, input logic hi);
    logic [7:0] v;
    v = hi ? {4'h0, code[11:8]} : code[7:0];
    return v;
  endfunction : ddlc_lane

  // Next portion: first or second half in the chosen order
  function automatic logic ddlc_half(input logic hi_first, input logic second);
    logic h;
    h = hi_first ^ second;
    return h;
  endfunction : ddlc_half

  // Portion to pin phase; shared by request capture and the switch between
  // halves so both ends of a request agree on which half is which
  function automatic ddlc_pkg::ddlc_phase_e ddlc_phase_of(input logic hi);
    ddlc_pkg::ddlc_phase_e p;
    p = hi ? ddlc_pkg::DDLC_PH_HIGH : ddlc_pkg::DDLC_PH_LOW;
    return p;
  endfunction : ddlc_phase_of

  // A strobe falls on the last setup cycle and rises when its count runs out.
  // Both strobes share this decode so their widths can never drift apart.
  function automatic logic ddlc_strobe_low(input ddlc_pkg::ddlc_state_e state,
                                           input logic [3:0]            cnt,
                                           input logic                  setup_match,
                                           input ddlc_pkg::ddlc_state_e strobe_state);
    logic low;
    low = (state == ddlc_pkg::DDLC_SETUP && cnt == 4'h0 && setup_match) ||
          (state == strobe_state && cnt != 4'h0);
    return low;
  endfunction : ddlc_strobe_low

  ////////////////////////////////////////////////////////////////////////////////
  // Handshake: a request is only taken from idle and never while the device
  // is held in reset, so no write strobe can land on a device being cleared
  assign req_ready = (state_q == ddlc_pkg::DDLC_IDLE) && !dev_rst_req && reset_n_q;
  assign done      = done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Device reset: write kept high through release so zeros stay latched.
  // Only asserted from idle, so a half-written code is never cut short;
  // the release comes one cycle after the request drops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_n_q <= 1'b0;
    end else if (dev_rst_req && state_q == ddlc_pkg::DDLC_IDLE) begin
      reset_n_q <= 1'b0;
    end else begin
      reset_n_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request capture and the write / transfer sequence.
  // One portion is SETUP, strobe, HOLD: the pins settle during SETUP, the
  // strobe stands for the whole strobe count, and HOLD keeps data steady
  // after the rising edge before anything moves again. The four-bit counter
  // limits each phase to sixteen cycles; longer timings need a wider count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ddlc_pkg::DDLC_IDLE;
      phase_q    <= ddlc_pkg::DDLC_PH_LOW;
      cnt_q      <= 4'h0;
      code_q     <= 12'h000;
      chan_q     <= 1'b0;
      hi_first_q <= 1'b0;
      xfer_q     <= 1'b0;
      second_q   <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ddlc_pkg::DDLC_IDLE: begin
          if (req_valid && req_ready) begin
            code_q     <= req_code;
            chan_q     <= req_chan;
            hi_first_q <= req_hi_first;
            xfer_q     <= req_transfer;
            second_q   <= 1'b0;
            phase_q    <= ddlc_phase_of(req_hi_first);
            cnt_q      <= 4'(`DDLC_SETUP_CYC - 1);
            state_q    <= ddlc_pkg::DDLC_SETUP;
          end
        end
        // Transfer phase leads to its own strobe state, never the write strobe
        ddlc_pkg::DDLC_SETUP: begin
          if (cnt_q == 4'h0) begin
            cnt_q   <= 4'(`DDLC_STROBE_CYC - 1);
            state_q <= (phase_q == ddlc_pkg::DDLC_PH_XFER) ? ddlc_pkg::DDLC_XSTRB
                                                          : ddlc_pkg::DDLC_WSTRB;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        // Both strobes last the same count; the pin logic tells them apart
        ddlc_pkg::DDLC_WSTRB, ddlc_pkg::DDLC_XSTRB: begin
          if (cnt_q == 4'h0) begin
            cnt_q   <= 4'(`DDLC_HOLD_CYC - 1);
            state_q <= ddlc_pkg::DDLC_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ddlc_pkg::DDLC_HOLD: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (phase_q != ddlc_pkg::DDLC_PH_XFER && !second_q) begin
            // Second portion next, in the order the request asked for
            second_q <= 1'b1;
            phase_q  <= ddlc_phase_of(ddlc_half(hi_first_q, 1'b1));
            cnt_q    <= 4'(`DDLC_SETUP_CYC - 1);
            state_q  <= ddlc_pkg::DDLC_SETUP;
          end else if (phase_q != ddlc_pkg::DDLC_PH_XFER && xfer_q) begin
            // Separate transfer pulse avoids the transparent path while writing
            phase_q <= ddlc_pkg::DDLC_PH_XFER;
            cnt_q   <= 4'(`DDLC_SETUP_CYC - 1);
            state_q <= ddlc_pkg::DDLC_SETUP;
          end else begin
            // Both halves and any transfer finished: done for one cycle
            done_q  <= 1'b1;
            state_q <= ddlc_pkg::DDLC_IDLE;
          end
        end
        default: begin
          // Illegal code: drop back to idle rather than hang the host
          state_q <= ddlc_pkg::DDLC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive: address and data stable around each strobe.
  // Re-driven on every write setup cycle with the same value, so the pins are
  // settled a full cycle before the strobe falls and never move under it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_data_q <= 8'h00;
      chan_sel_q <= 1'b0;
      byte_sel_q <= 1'b0;
    end else if (state_q == ddlc_pkg::DDLC_SETUP && phase_q != ddlc_pkg::DDLC_PH_XFER) begin
      chan_sel_q <= chan_q;
      byte_sel_q <= (phase_q == ddlc_pkg::DDLC_PH_HIGH);
      dac_data_q <= ddlc_lane(code_q, phase_q == ddlc_pkg::DDLC_PH_HIGH);
    end
  end

  // Write strobe low only for the addressed portion; high otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_n_q <= 1'b1;
    end else begin
      write_n_q <= !ddlc_strobe_low(state_q, cnt_q, phase_q != ddlc_pkg::DDLC_PH_XFER,
                                    ddlc_pkg::DDLC_WSTRB);
    end
  end

  // Transfer strobe: rising edge commits both channels at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_strobe_n_q <= 1'b1;
    end else begin
      transfer_strobe_n_q <= !ddlc_strobe_low(state_q, cnt_q,
                                              phase_q == ddlc_pkg::DDLC_PH_XFER,
                                              ddlc_pkg::DDLC_XSTRB);
    end
  end

endmodule : ddlc_host
`default_nettype wire

// ===== hdl/ddlc_pkg.sv
`default_nettype none
package ddlc_pkg;
  typedef enum logic [2:0] {
    DDLC_IDLE  = 3'b000,
    DDLC_SETUP = 3'b001,
    DDLC_WSTRB = 3'b010,
    DDLC_HOLD  = 3'b011,
    DDLC_XSTRB = 3'b100
  } ddlc_state_e;
  typedef enum logic [1:0] {
    DDLC_PH_LOW  = 2'b00,
    DDLC_PH_HIGH = 2'b01,
    DDLC_PH_XFER = 2'b10
  } ddlc_phase_e;
endpackage : ddlc_pkg
`default_nettype wire

// ===== hdl/ddlc_regs.svh
`ifndef DDLC_REGS_SVH
`define DDLC_REGS_SVH
// Widths of the converter port and codes
`define DDLC_DATA_W      8
`define DDLC_CODE_W      12
`define DDLC_HI_W        4
// Strobe timing, in ns and in 250 MHz cycles
`define DDLC_CLK_NS      4
`define DDLC_SETUP_NS    8
`define DDLC_SETUP_CYC   ((`DDLC_SETUP_NS + `DDLC_CLK_NS - 1) / `DDLC_CLK_NS)
`define DDLC_STROBE_NS   12
`define DDLC_STROBE_CYC  ((`DDLC_STROBE_NS + `DDLC_CLK_NS - 1) / `DDLC_CLK_NS)
`define DDLC_HOLD_NS     8
`define DDLC_HOLD_CYC    ((`DDLC_HOLD_NS + `DDLC_CLK_NS - 1) / `DDLC_CLK_NS)
`endif

// ===== tb/ddlc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ddlc_dev (
  input wire logic [7:0]  dac_data_q,
  input wire logic        chan_sel_q,
  input wire logic        byte_sel_q,
  input wire logic        write_n_q,
  input wire logic        transfer_strobe_n_q,
  input wire logic        reset_n_q,
  output logic     [11:0] out_a,
  output logic     [11:0] out_b
);
  logic [7:0] lo_a, lo_b;
  logic [3:0] hi_a, hi_b;
  // Input latches follow the port while write is low; either half may come first
  always_latch begin
    if (!reset_n_q) begin
      {lo_a, lo_b, hi_a, hi_b} <= 24'h000000;
    end else if (!write_n_q) begin
      case ({chan_sel_q, byte_sel_q})
        2'b00: lo_a <= dac_data_q;
        2'b01: hi_a <= dac_data_q[3:0];
        2'b10: lo_b <= dac_data_q;
        default: hi_b <= dac_data_q[3:0];
      endcase
    end
  end
  // Output latches are open while transfer is low, so with write low too they pass through
  always_latch begin
    if (!reset_n_q) begin
      {out_a, out_b} <= 24'h000000;
    end else if (!transfer_strobe_n_q) begin
      out_a <= {hi_a, lo_a};
      out_b <= {hi_b, lo_b};
    end
  end
endmodule : ddlc_dev
`default_nettype wire

// ===== tb/ddlc_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ddlc_host_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_transfer,
  input wire logic       done,
  input wire logic [7:0] dac_data_q,
  input wire logic       chan_sel_q,
  input wire logic       byte_sel_q,
  input wire logic       write_n_q,
  input wire logic       transfer_strobe_n_q,
  input wire logic       reset_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A strobe stays low for exactly three cycles, shorter would break device timing
  sequence s_low3(sig);
    (!sig)[*3] ##1 sig;
  endsequence
  a_write_width: assert property ($fell(write_n_q) |-> s_low3(write_n_q))
    else $error("write strobe width wrong");
  a_xfer_width: assert property ($fell(transfer_strobe_n_q) |-> s_low3(transfer_strobe_n_q))
    else $error("transfer strobe width wrong");
  a_nibble_right: assert property (!write_n_q && byte_sel_q |-> dac_data_q[7:4] == 4'h0)
    else $error("nibble not right-justified");
  a_pins_steady: assert property (!write_n_q |-> $stable(dac_data_q) && $stable(chan_sel_q)
    && $stable(byte_sel_q)) else $error("pins moved under write strobe");
  a_no_overlap: assert property (!transfer_strobe_n_q |-> write_n_q)
    else $error("transfer overlaps write");
  a_reset_write_high: assert property (!reset_n_q |-> write_n_q)
    else $error("write low during device reset");
  a_done_plain: assert property (req_valid && req_ready && !req_transfer |-> ##[14:15] done)
    else $error("load without transfer late");
  a_done_xfer: assert property (req_valid && req_ready && req_transfer |-> ##[21:22] done)
    else $error("load with transfer late");
endmodule : ddlc_host_sva
bind ddlc_host ddlc_host_sva chk (
  .clk                 (clk),
  .rst                 (rst),
  .req_valid           (req_valid),
  .req_ready           (req_ready),
  .req_transfer        (req_transfer),
  .done                (done),
  .dac_data_q          (dac_data_q),
  .chan_sel_q          (chan_sel_q),
  .byte_sel_q          (byte_sel_q),
  .write_n_q           (write_n_q),
  .transfer_strobe_n_q (transfer_strobe_n_q),
  .reset_n_q           (reset_n_q)
);
`default_nettype wire

// ===== tb/test_ddlc_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_ddlc_host;
  logic        clk = 0, rst = 1, req_valid = 0, req_chan = 0, req_hi_first = 0;
  logic        req_transfer = 0, dev_rst_req = 0, req_ready, done, chan_sel_q, byte_sel_q;
  logic        write_n_q, transfer_strobe_n_q, reset_n_q;
  logic [7:0]  dac_data_q;
  logic [11:0] req_code = 12'h000, out_a, out_b;
  int          failures = 0, checks = 0;
  initial forever #2 clk = ~clk;
  ddlc_host uut (
    .clk                 (clk),
    .rst                 (rst),
    .req_valid           (req_valid),
    .req_ready           (req_ready),
    .req_chan            (req_chan),
    .req_code            (req_code),
    .req_hi_first        (req_hi_first),
    .req_transfer        (req_transfer),
    .dev_rst_req         (dev_rst_req),
    .done                (done),
    .dac_data_q          (dac_data_q),
    .chan_sel_q          (chan_sel_q),
    .byte_sel_q          (byte_sel_q),
    .write_n_q           (write_n_q),
    .transfer_strobe_n_q (transfer_strobe_n_q),
    .reset_n_q           (reset_n_q)
  );
  ddlc_dev dev (
    .dac_data_q          (dac_data_q),
    .chan_sel_q          (chan_sel_q),
    .byte_sel_q          (byte_sel_q),
    .write_n_q           (write_n_q),
    .transfer_strobe_n_q (transfer_strobe_n_q),
    .reset_n_q           (reset_n_q),
    .out_a               (out_a),
    .out_b               (out_b)
  );
  task check(string nm, logic [11:0] got, logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Ready is looked at mid-cycle, so valid drops right after the taking edge
  task load(logic ch, logic [11:0] c, logic hf, logic xf);
    int n;
    n = 0;
    req_valid <= 1; req_chan <= ch; req_code <= c; req_hi_first <= hf; req_transfer <= xf;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 60);
    if (req_ready !== 1'b1) begin failures++; summarize; end
    @(posedge clk) req_valid <= 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 90);
    if (done !== 1'b1) begin failures++; summarize; end
    @(posedge clk);
  endtask : load
  task s_order;
    load(0, 12'h5A3, 0, 0);
    check("a held", out_a, 12'h000);
    load(1, 12'h9C4, 1, 1);
    check("a out", out_a, 12'h5A3);
    check("b out", out_b, 12'h9C4);
  endtask : s_order
  task s_bounds;
    load(0, 12'hFFF, 1, 0);
    load(1, 12'h000, 0, 1);
    check("a full", out_a, 12'hFFF);
    check("b zero", out_b, 12'h000);
  endtask : s_bounds
  task s_dev_reset;
    int n;
    n = 0;
    dev_rst_req <= 1;
    do begin @(negedge clk); n++; end while (reset_n_q !== 1'b0 && n < 20);
    if (reset_n_q !== 1'b0) begin failures++; summarize; end
    check("a reset", out_a, 12'h000);
    check("b reset", out_b, 12'h000);
    @(posedge clk) dev_rst_req <= 0;
    load(0, 12'h123, 0, 1);
    check("a after", out_a, 12'h123);
    check("b after", out_b, 12'h000);
  endtask : s_dev_reset
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(negedge clk) check("a init", out_a, 12'h000);
    @(posedge clk);
    s_order;
    s_bounds;
    s_dev_reset;
    summarize;
  end
endmodule : test_ddlc_host
`default_nettype wire
